// >>> isd_pkg.sv
/*
  Constants, types and layouts shared by the instruction set decoder: opcode
  map, operate and transfer bit positions, memory cycle timing, register map.
  Assumes a 100 MHz clock and one core memory word per address.
*/
// Contract
// - indirect bit fetches pointer, bits 5-17 address
// - pointer's own indirect bit is ignored
// - pointers in cells 10-17 octal pre-increment
// - opcode 00 calls through cell 20
// - opcode 04 stores work_register, sixteen microseconds
// - opcode 10 saves carry and pointer, jumps
// - opcode 14 zeroes the cell
// - opcode 20 loads work_register from cell
// - opcode 24 exclusive-ORs cell into work_register
// - opcode 30 one's complement add, overflow sets carry
// - opcode 34 two's complement add, carry sets
// - opcode 40 executes the word in cell
// - opcode 44 increments cell, skips on zero
// - opcode 50 ANDs cell into work_register
// - opcode 54 skips when work_register differs
// - opcode 60 jumps in one cycle
// - operate skip conditions ORed, bit 1000 inverts
// - rotate work_register with carry, optional twice
// - operate steps: clears, modify, rotate, halt
// - bit 4 set loads immediate with ones
// - transfer bit 14 clears work_register at event 1
// - events 1,2 late; event 3 next instruction
// - bits 17,16,15 give pulses at events 1,2,3
// - device code from instruction bits 6-11
package isd_pkg;

  localparam int W  = 18;
  localparam int AW = 13;

  // instruction word: bit 0 of the word is bit 17 here
  localparam int B_OP_HI = 17;
  localparam int B_OP_LO = 14;
  localparam int B_IND   = 13;

  localparam logic [3:0] OP_CAL = 4'h0;
  localparam logic [3:0] OP_DAC = 4'h1;
  localparam logic [3:0] OP_JMS = 4'h2;
  localparam logic [3:0] OP_DZM = 4'h3;
  localparam logic [3:0] OP_LAC = 4'h4;
  localparam logic [3:0] OP_XOR = 4'h5;
  localparam logic [3:0] OP_ADD = 4'h6;
  localparam logic [3:0] OP_TAD = 4'h7;
  localparam logic [3:0] OP_XCT = 4'h8;
  localparam logic [3:0] OP_ISZ = 4'h9;
  localparam logic [3:0] OP_AND = 4'hA;
  localparam logic [3:0] OP_SAD = 4'hB;
  localparam logic [3:0] OP_JMP = 4'hC;
  localparam logic [3:0] OP_NUL = 4'hD;
  localparam logic [3:0] OP_IOT = 4'hE;
  localparam logic [3:0] OP_OPR = 4'hF;

  localparam logic [AW-1:0] CALL_CELL = 13'h0010;
  localparam logic [AW-1:0] AUTO_LO   = 13'h0008;
  localparam logic [AW-1:0] AUTO_HI   = 13'h000F;
  localparam logic [4:0]    LAW_ONES  = 5'h1F;

  // operate group bit positions
  localparam int OB_CMA = 0;
  localparam int OB_CML = 1;
  localparam int OB_OAS = 2;
  localparam int OB_RAL = 3;
  localparam int OB_RAR = 4;
  localparam int OB_HLT = 5;
  localparam int OB_SMA = 6;
  localparam int OB_SZA = 7;
  localparam int OB_SNL = 8;
  localparam int OB_INV = 9;
  localparam int OB_ROT2 = 10;
  localparam int OB_CLL = 11;
  localparam int OB_CLA = 12;

  // transfer group bit positions
  localparam int IB_EV1 = 0;
  localparam int IB_EV2 = 1;
  localparam int IB_EV3 = 2;
  localparam int IB_CLR = 3;
  localparam int IB_DEV_LO = 6;
  localparam int IB_DEV_HI = 11;

  // timing
  localparam int CLK_NS       = 10;
  localparam int MEM_CYCLE_NS = 8000;
  localparam int IOT1_AT_NS   = 5000;
  localparam int IOT12_NS     = 2000;
  localparam int IOT23_NS     = 1200;
  localparam int MEM_CYC  = MEM_CYCLE_NS / CLK_NS;
  localparam int EV1_CYC  = IOT1_AT_NS / CLK_NS;
  localparam int EV2_CYC  = EV1_CYC + IOT12_NS / CLK_NS;
  localparam int EV3_CYC  = EV2_CYC + IOT23_NS / CLK_NS - MEM_CYC;
  localparam int CNT_W    = 10;

  // register map (byte addresses)
  localparam int PAW = 12;
  localparam logic [PAW-1:0] REG_CTRL   = 12'h000;
  localparam logic [PAW-1:0] REG_PC     = 12'h004;
  localparam logic [PAW-1:0] REG_AC     = 12'h008;
  localparam logic [PAW-1:0] REG_SW     = 12'h00C;
  localparam logic [PAW-1:0] REG_STATUS = 12'h010;
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_DEFER = 4'b0100,
    ST_EXEC  = 4'b1000
  } isd_state_t;

  typedef struct packed {
    logic          rd;
    logic [AW-1:0] rd_addr;
    logic          wr;
    logic [AW-1:0] wr_addr;
    logic [W-1:0]  wdata;
  } isd_mem_req_t;

  typedef struct packed {
    logic [2:0] pulse;
    logic [5:0] device;
  } isd_iot_t;

endpackage : isd_pkg

// >>> isd_decoder.sv
/*
  Fetch, defer and execute sequencer with the memory reference, operate,
  load-immediate and input-output transfer groups, plus an APB slave.
  Assumes core memory answers each read with one rvalid pulse on this clock.
*/
module isd_decoder #(
  parameter int MEM_CYCLES = isd_pkg::MEM_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [isd_pkg::PAW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output      logic [31:0]            prdata,
  output      logic                   pready,
  output      logic                   pslverr,
  output      isd_pkg::isd_mem_req_t  mem_req,
  input  wire logic                   mem_rvalid,
  input  wire logic [isd_pkg::W-1:0]  mem_rdata,
  output      isd_pkg::isd_iot_t      iot_out
);

  if (MEM_CYCLES <= isd_pkg::EV2_CYC + 1 ||
      MEM_CYCLES >= 2 ** isd_pkg::CNT_W) begin : g_bad_cycles
    $error("MEM_CYCLES out of range");
  end

  localparam logic [isd_pkg::CNT_W-1:0] LAST =
    isd_pkg::CNT_W'(MEM_CYCLES - 1);
  localparam logic [isd_pkg::CNT_W-1:0] EV1 = isd_pkg::CNT_W'(isd_pkg::EV1_CYC);
  localparam logic [isd_pkg::CNT_W-1:0] EV2 = isd_pkg::CNT_W'(isd_pkg::EV2_CYC);
  localparam logic [isd_pkg::CNT_W-1:0] EV3 = isd_pkg::CNT_W'(isd_pkg::EV3_CYC);

  isd_pkg::isd_state_t            st;
  isd_pkg::isd_state_t            next_st;
  logic [isd_pkg::CNT_W-1:0]      cnt;
  logic                           have_data;
  logic [isd_pkg::W-1:0]          memory_word_latch;
  logic [isd_pkg::W-1:0]          work_register;
  logic                           carry_bit;
  logic [isd_pkg::AW-1:0]         next_instr_pointer;
  logic [isd_pkg::W-1:0]          front_panel_switches;
  logic [3:0]                     ir;
  logic [isd_pkg::AW-1:0]         ea;
  logic [isd_pkg::AW-1:0]         cur_addr;
  logic                           run;
  logic                           ev3_pend;

  logic                           cyc_end;
  logic                           dec_now;
  logic                           launch;
  logic                           apb_wr;
  logic                           stop_req;
  logic                           iot_cyc;
  logic                           ev1;
  logic                           ev2;
  logic [3:0]                     op;
  logic [isd_pkg::W-1:0]          d;
  logic [isd_pkg::W-1:0]          next_ac;
  logic [isd_pkg::W-1:0]          wb;
  logic                           next_link;
  logic [isd_pkg::AW-1:0]         next_pc;
  logic [isd_pkg::AW-1:0]         next_addr;
  logic [isd_pkg::AW-1:0]         next_ea;
  logic [3:0]                     next_ir;
  logic                           next_halt;

  // ==========================================================
  // cycle timing
  assign d       = memory_word_latch;
  assign op      = d[isd_pkg::B_OP_HI:isd_pkg::B_OP_LO];
  assign cyc_end = (st != isd_pkg::ST_IDLE) && (cnt == LAST) && have_data;
  assign dec_now = (st == isd_pkg::ST_FETCH) ||
                   (st == isd_pkg::ST_EXEC && ir == isd_pkg::OP_XCT);
  assign apb_wr  = psel && penable && pwrite;
  assign launch  = apb_wr && paddr == isd_pkg::REG_CTRL &&
                   pwdata[isd_pkg::CTRL_START] && st == isd_pkg::ST_IDLE;
  assign stop_req = apb_wr && paddr == isd_pkg::REG_CTRL &&
                    pwdata[isd_pkg::CTRL_STOP];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (launch || cyc_end) begin
      cnt <= '0;
    end else if (st != isd_pkg::ST_IDLE && (cnt == '0 || have_data) &&
                 cnt != LAST) begin
      cnt <= cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      have_data         <= 1'b0;
      memory_word_latch <= '0;
    end else if (launch || cyc_end) begin
      have_data <= 1'b0;
    end else if (mem_rvalid && !have_data && st != isd_pkg::ST_IDLE) begin
      have_data         <= 1'b1;
      memory_word_latch <= mem_rdata;
    end
  end

  // ==========================================================
  // decode and execute
  always_comb begin
    logic [isd_pkg::AW-1:0] y;
    logic [isd_pkg::AW-1:0] pc_base;
    logic [isd_pkg::W:0]    sum;
    logic [isd_pkg::W-1:0]  t_ac;
    logic                   t_l;
    logic                   sk;
    y         = '0;
    pc_base   = '0;
    sum       = '0;
    t_ac      = '0;
    t_l       = 1'b0;
    sk        = 1'b0;
    next_st   = isd_pkg::ST_FETCH;
    next_pc   = next_instr_pointer;
    next_ac   = work_register;
    next_link = carry_bit;
    next_ir   = ir;
    next_ea   = ea;
    next_halt = 1'b0;
    wb        = d;
    if (dec_now) begin
      pc_base = (st == isd_pkg::ST_FETCH) ? next_instr_pointer + 1'b1
                                          : next_instr_pointer;
      next_pc = pc_base;
      next_ir = op;
      y = (op == isd_pkg::OP_CAL) ? isd_pkg::CALL_CELL : d[isd_pkg::AW-1:0];
      next_ea = y;
      if (op == isd_pkg::OP_OPR && d[isd_pkg::B_IND]) begin
        next_ac = {isd_pkg::LAW_ONES, d[isd_pkg::AW-1:0]};
      end else if (op == isd_pkg::OP_OPR) begin
        sk = (d[isd_pkg::OB_SMA] && work_register[isd_pkg::W-1]) ||
             (d[isd_pkg::OB_SZA] && work_register == '0) ||
             (d[isd_pkg::OB_SNL] && carry_bit);
        if (d[isd_pkg::OB_INV]) sk = !sk;
        t_l  = d[isd_pkg::OB_CLL] ? 1'b0 : carry_bit;
        t_ac = d[isd_pkg::OB_CLA] ? '0 : work_register;
        if (d[isd_pkg::OB_CMA]) t_ac = ~t_ac;
        if (d[isd_pkg::OB_CML]) t_l = !t_l;
        if (d[isd_pkg::OB_OAS]) t_ac = t_ac | front_panel_switches;
        for (int k = 0; k < 2; k++) begin
          if (k == 0 || d[isd_pkg::OB_ROT2]) begin
            if (d[isd_pkg::OB_RAL]) {t_l, t_ac} = {t_ac, t_l};
            if (d[isd_pkg::OB_RAR]) {t_l, t_ac} = {t_ac[0], t_l,
                                                   t_ac[isd_pkg::W-1:1]};
          end
        end
        next_ac   = t_ac;
        next_link = t_l;
        next_halt = d[isd_pkg::OB_HLT];
        next_pc   = pc_base + {{(isd_pkg::AW-1){1'b0}}, sk};
      end else if (op == isd_pkg::OP_IOT || op == isd_pkg::OP_NUL) begin
        next_st = isd_pkg::ST_FETCH;
      end else if (d[isd_pkg::B_IND]) begin
        next_st = isd_pkg::ST_DEFER;
      end else if (op == isd_pkg::OP_JMP) begin
        next_pc = y;
      end else begin
        next_st = isd_pkg::ST_EXEC;
      end
    end else if (st == isd_pkg::ST_DEFER) begin
      if (cur_addr >= isd_pkg::AUTO_LO && cur_addr <= isd_pkg::AUTO_HI)
        wb = d + 1'b1;
      next_ea = wb[isd_pkg::AW-1:0];
      if (ir == isd_pkg::OP_JMP) next_pc = next_ea;
      else next_st = isd_pkg::ST_EXEC;
    end else if (st == isd_pkg::ST_EXEC) begin
      case (ir)
        isd_pkg::OP_CAL, isd_pkg::OP_JMS: begin
          wb      = {carry_bit, 4'h0, next_instr_pointer};
          next_pc = ea + 1'b1;
        end
        isd_pkg::OP_DAC: wb = work_register;
        isd_pkg::OP_DZM: wb = '0;
        isd_pkg::OP_LAC: next_ac = d;
        isd_pkg::OP_XOR: next_ac = work_register ^ d;
        isd_pkg::OP_AND: next_ac = work_register & d;
        isd_pkg::OP_ADD: begin
          sum     = {1'b0, work_register} + {1'b0, d};
          next_ac = sum[isd_pkg::W-1:0] + {{(isd_pkg::W-1){1'b0}},
                                           sum[isd_pkg::W]};
          if (work_register[isd_pkg::W-1] == d[isd_pkg::W-1] &&
              next_ac[isd_pkg::W-1] != d[isd_pkg::W-1])
            next_link = 1'b1;
        end
        isd_pkg::OP_TAD: begin
          sum     = {1'b0, work_register} + {1'b0, d};
          next_ac = sum[isd_pkg::W-1:0];
          if (sum[isd_pkg::W]) next_link = 1'b1;
        end
        isd_pkg::OP_ISZ: begin
          wb = d + 1'b1;
          if (wb == '0) next_pc = next_instr_pointer + 1'b1;
        end
        isd_pkg::OP_SAD: begin
          if (work_register != d)
            next_pc = next_instr_pointer + 1'b1;
        end
        default: next_st = isd_pkg::ST_FETCH;
      endcase
    end
    case (next_st)
      isd_pkg::ST_DEFER: next_addr = y;
      isd_pkg::ST_EXEC:  next_addr = next_ea;
      default:           next_addr = next_pc;
    endcase
  end

  // ==========================================================
  // sequencer state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st       <= isd_pkg::ST_IDLE;
      cur_addr <= '0;
      ir       <= '0;
      ea       <= '0;
    end else if (launch) begin
      st       <= isd_pkg::ST_FETCH;
      cur_addr <= next_instr_pointer;
    end else if (cyc_end) begin
      ir       <= next_ir;
      ea       <= next_ea;
      cur_addr <= next_addr;
      if (next_st == isd_pkg::ST_FETCH && (!run || next_halt || stop_req))
        st <= isd_pkg::ST_IDLE;
      else
        st <= next_st;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
    end else if (launch) begin
      run <= 1'b1;
    end else if (stop_req || (cyc_end && next_halt)) begin
      run <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      next_instr_pointer <= '0;
      carry_bit          <= 1'b0;
    end else if (cyc_end) begin
      next_instr_pointer <= next_pc;
      carry_bit          <= next_link;
    end else if (apb_wr && paddr == isd_pkg::REG_PC &&
                 st == isd_pkg::ST_IDLE) begin
      next_instr_pointer <= pwdata[isd_pkg::AW-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      work_register <= '0;
    end else if (cyc_end) begin
      work_register <= next_ac;
    end else if (ev1 && d[isd_pkg::IB_CLR]) begin
      work_register <= '0;
    end else if (apb_wr && paddr == isd_pkg::REG_AC &&
                 st == isd_pkg::ST_IDLE) begin
      work_register <= pwdata[isd_pkg::W-1:0];
    end
  end

  // ==========================================================
  // core memory strobes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_req <= '0;
    end else begin
      mem_req.rd <= 1'b0;
      mem_req.wr <= 1'b0;
      if (launch) begin
        mem_req.rd      <= 1'b1;
        mem_req.rd_addr <= next_instr_pointer;
      end else if (cyc_end) begin
        mem_req.wr      <= 1'b1;
        mem_req.wr_addr <= cur_addr;
        mem_req.wdata   <= wb;
        if (!(next_st == isd_pkg::ST_FETCH &&
              (!run || next_halt || stop_req))) begin
          mem_req.rd      <= 1'b1;
          mem_req.rd_addr <= next_addr;
        end
      end
    end
  end

  // ==========================================================
  // input-output transfer events
  assign iot_cyc = dec_now && have_data && op == isd_pkg::OP_IOT;
  assign ev1     = iot_cyc && cnt == EV1;
  assign ev2     = iot_cyc && cnt == EV2;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      iot_out  <= '0;
      ev3_pend <= 1'b0;
    end else begin
      iot_out.pulse[0] <= ev1 && d[isd_pkg::IB_EV1];
      iot_out.pulse[1] <= ev2 && d[isd_pkg::IB_EV2];
      iot_out.pulse[2] <= ev3_pend && (st == isd_pkg::ST_IDLE ||
                                       cnt == EV3);
      if (ev1) begin
        iot_out.device <= d[isd_pkg::IB_DEV_HI:isd_pkg::IB_DEV_LO];
        ev3_pend       <= d[isd_pkg::IB_EV3];
      end else if (st == isd_pkg::ST_IDLE || cnt == EV3) begin
        ev3_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // apb slave
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == isd_pkg::REG_CTRL ||
    paddr == isd_pkg::REG_PC || paddr == isd_pkg::REG_AC ||
    paddr == isd_pkg::REG_SW || paddr == isd_pkg::REG_STATUS);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      front_panel_switches <= '0;
    end else if (apb_wr && paddr == isd_pkg::REG_SW) begin
      front_panel_switches <= pwdata[isd_pkg::W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      case (paddr)
        isd_pkg::REG_CTRL:   prdata <= {31'h0, run};
        isd_pkg::REG_PC:     prdata <= {19'h0, next_instr_pointer};
        isd_pkg::REG_AC:     prdata <= {14'h0, work_register};
        isd_pkg::REG_SW:     prdata <= {14'h0, front_panel_switches};
        isd_pkg::REG_STATUS: prdata <= {22'h0, ir, st, carry_bit, run};
        default:             prdata <= '0;
      endcase
    end
  end

  // ==========================================================
  // checks
  property p_ind_defer;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_FETCH && d[isd_pkg::B_IND] && op < 4'hD
    |=> st == isd_pkg::ST_DEFER && cur_addr == $past(next_addr);
  endproperty
  a_ind_defer: assert property (p_ind_defer)
    else $error("indirect word did not enter defer");

  property p_one_level;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_DEFER |=> st != isd_pkg::ST_DEFER;
  endproperty
  a_one_level: assert property (p_one_level)
    else $error("second defer cycle");

  property p_autoinc;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_DEFER && cur_addr >= isd_pkg::AUTO_LO &&
    cur_addr <= isd_pkg::AUTO_HI
    |=> mem_req.wr && mem_req.wdata == $past(d) + 1'b1;
  endproperty
  a_autoinc: assert property (p_autoinc)
    else $error("auto index cell not incremented");

  property p_dac;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_EXEC && ir == isd_pkg::OP_DAC
    |=> mem_req.wdata == $past(work_register) &&
        $stable(work_register);
  endproperty
  a_dac: assert property (p_dac)
    else $error("store wrote wrong value");

  property p_dzm;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_EXEC && ir == isd_pkg::OP_DZM
    |=> mem_req.wr && mem_req.wdata == '0;
  endproperty
  a_dzm: assert property (p_dzm)
    else $error("cell not zeroed");

  property p_lac;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_EXEC && ir == isd_pkg::OP_LAC
    |=> work_register == $past(d);
  endproperty
  a_lac: assert property (p_lac)
    else $error("load missed");

  property p_sad;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_EXEC && ir == isd_pkg::OP_SAD &&
    work_register != d
    |=> next_instr_pointer == $past(next_instr_pointer) + 1'b1;
  endproperty
  a_sad: assert property (p_sad)
    else $error("compare skip missing");

  property p_jmp;
    @(posedge clk) disable iff (!reset_n)
    cyc_end && st == isd_pkg::ST_FETCH && op == isd_pkg::OP_JMP &&
    !d[isd_pkg::B_IND]
    |=> next_instr_pointer == $past(d[isd_pkg::AW-1:0]) &&
        st != isd_pkg::ST_EXEC;
  endproperty
  a_jmp: assert property (p_jmp)
    else $error("jump not single cycle");

  property p_iot_clear;
    @(posedge clk) disable iff (!reset_n)
    ev1 && d[isd_pkg::IB_CLR] |=> work_register == '0;
  endproperty
  a_iot_clear: assert property (p_iot_clear)
    else $error("transfer did not clear");

  property p_iot_pulse;
    @(posedge clk) disable iff (!reset_n)
    ev1 && d[isd_pkg::IB_EV1] |=> iot_out.pulse[0] ##1 !iot_out.pulse[0];
  endproperty
  a_iot_pulse: assert property (p_iot_pulse)
    else $error("event 1 pulse wrong");

endmodule : isd_decoder

// >>> isd_core_mem.sv
/*
  Core memory partner: destructive read, one rvalid pulse per rd.
  Assumes rd/wr pulses from the decoder on the same clock.
*/
module isd_core_mem (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire isd_pkg::isd_mem_req_t  mem_req,
  output      logic                   mem_rvalid,
  output      logic [isd_pkg::W-1:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] cells [0:8191];
  logic [12:0] addr;
  logic [5:0]  cnt;
  logic        slow;
  // ==========================================================
  // read answer, alternately prompt and slow
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= 18'h2AAAA;
      cnt        <= 6'h00;
      slow       <= 1'b0;
    end else begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata;
      if (mem_req.wr) cells[mem_req.wr_addr] <= mem_req.wdata;
      if (mem_req.rd) begin
        addr <= mem_req.rd_addr;
        cnt  <= slow ? 6'h28 : 6'h01;
        slow <= !slow;
      end else if (cnt != 6'h00) begin
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          mem_rvalid  <= 1'b1;
          mem_rdata   <= cells[addr];
          cells[addr] <= 18'h00000;
        end
      end
    end
  end
endmodule : isd_core_mem

// >>> tb.sv
/*
  Self-checking bench: reference interpreter against the decoder.
  Assumes the core memory partner and APB with pready tied high.
*/
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, mem_rvalid, e, lk, run, sk;
  logic [17:0] mem_rdata, ac, sw, rm [0:8191];
  logic [12:0] pc;
  isd_pkg::isd_mem_req_t mem_req;
  isd_pkg::isd_iot_t     iot_out;
  int failures = 0, total_checks = 0, cyc = 0, ev [3];
  logic [30:0] ld [23] = '{{13'h40, 18'h3C800}, {13'h41, 18'h10100},
    {13'h42, 18'h18101}, {13'h43, 18'h04102}, {13'h44, 18'h1E008},
    {13'h45, 18'h14101}, {13'h46, 18'h28103}, {13'h47, 18'h24104},
    {13'h48, 18'h0C100}, {13'h49, 18'h2C101}, {13'h4A, 18'h0C101},
    {13'h4B, 18'h0C103}, {13'h4C, 18'h08110}, {13'h4D, 18'h20105},
    {13'h4E, 18'h00123}, {13'h4F, 18'h3CE48}, {13'h50, 18'h3D086},
    {13'h51, 18'h3EABC}, {13'h52, 18'h38B4F}, {13'h53, 18'h30060},
    {13'h60, 18'h3C020}, {13'h111, 18'h32110}, {13'h11, 18'h32010}};
  isd_decoder dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .iot_out(iot_out));
  isd_core_mem mem (.clk(clk), .reset_n(reset_n), .mem_req(mem_req),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 3; i++) if (iot_out.pulse[i] === 1'b1) ev[i]++;
    if (cyc == 90000) begin
      failures++;
      end_of_test();
    end
  end
  task end_of_test;
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // ==========================================================
  // reference interpreter
  function logic [12:0] ea(input logic [17:0] w);
    logic [12:0] y;
    y = (w[17:14] == 4'h0) ? 13'h10 : w[12:0];
    if (w[13]) begin
      if (y >= 8 && y <= 15) rm[y] = rm[y] + 18'h1;
      y = rm[y][12:0];
    end
    return y;
  endfunction : ea
  task ref_run;
    logic [17:0] w, m;
    logic [18:0] s;
    logic [12:0] y;
    while (run) begin
      w = rm[pc];
      pc++;
      while (w[17:14] == 4'h8) w = rm[ea(w)];
      y = (w[17:14] < 4'hE) ? ea(w) : 13'h0;
      m = rm[y];
      case (w[17:14])
        4'h0, 4'h2: begin
          rm[y] = {lk, 4'h0, pc};
          pc = y + 13'h1;
        end
        4'h1: rm[y] = ac;
        4'h3: rm[y] = 18'h0;
        4'h4: ac = m;
        4'h5: ac = ac ^ m;
        4'h6: begin
          s = ac + m;
          s = s[17:0] + s[18];
          lk |= (ac[17] == m[17]) && (s[17] != ac[17]);
          ac = s[17:0];
        end
        4'h7: begin
          s = ac + m;
          lk |= s[18];
          ac = s[17:0];
        end
        4'h9: begin
          rm[y] = m + 18'h1;
          if (rm[y] == 18'h0) pc++;
        end
        4'hA: ac = ac & m;
        4'hB: if (ac != m) pc++;
        4'hC: pc = y;
        4'hE: if (w[3]) ac = 18'h0;
        4'hF: if (w[13]) ac = {5'h1F, w[12:0]};
        else begin
          sk = (w[6] & ac[17]) | (w[7] & (ac == 0)) | (w[8] & lk);
          if (w[9]) sk = !sk;
          if (w[11]) lk = 1'b0;
          if (w[12]) ac = 18'h0;
          if (w[0]) ac = ~ac;
          if (w[1]) lk = !lk;
          if (w[2]) ac = ac | sw;
          repeat (w[10] ? 2 : 1) begin
            if (w[3]) {lk, ac} = {ac, lk};
            if (w[4]) {ac, lk} = {lk, ac};
          end
          if (w[5]) run = 1'b0;
          if (sk) pc++;
        end
        default: ;
      endcase
    end
  endtask : ref_run
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h074C24AB));
    for (int i = 0; i < 23; i++) mem.cells[ld[i][30:18]] = ld[i][17:0];
    for (int i = 0; i < 4; i++) mem.cells[13'h100 + i] = 18'($urandom);
    mem.cells[13'h104] = 18'h3FFFF;
    mem.cells[13'h105] = {5'h1F, 13'($urandom)};
    mem.cells[13'h8] = 18'h000FF;
    sw = 18'($urandom);
    rm = mem.cells;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, isd_pkg::REG_STATUS, 32'h0);
    `CHK("status", 32'h00000004, r)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", 33'h100000000, {e, r})
    apb(1'b1, isd_pkg::REG_SW, {14'h0, sw});
    ac = 18'($urandom);
    apb(1'b1, isd_pkg::REG_AC, {14'h0, ac});
    apb(1'b1, isd_pkg::REG_PC, 32'h40);
    apb(1'b0, isd_pkg::REG_SW, 32'h0);
    `CHK("switches", {14'h0, sw}, r)
    apb(1'b1, isd_pkg::REG_CTRL, 32'h1);
    pc = 13'h40;
    lk = 1'b0;
    run = 1'b1;
    ref_run();
    repeat (150) begin
      repeat (500) @(posedge clk);
      apb(1'b0, isd_pkg::REG_STATUS, 32'h0);
      if (r[0] === 1'b0) break;
    end
    `CHK("halted", 1'b0, r[0])
    `CHK("link", lk, r[1])
    apb(1'b0, isd_pkg::REG_AC, 32'h0);
    `CHK("work_register", {14'h0, ac}, r)
    apb(1'b0, isd_pkg::REG_PC, 32'h0);
    `CHK("next_instr_pointer", {19'h0, pc}, r)
    for (int a = 0; a < 13'h120; a++)
      `CHK("cell", rm[a], mem.cells[a])
    for (int i = 0; i < 3; i++) `CHK("iot pulses", 1, ev[i])
    `CHK("device", 6'h2D, iot_out.device)
    end_of_test();
  end
endmodule : tb
